// *** hdl/oss_pkg.sv ***
// Purpose: Shared constants for the optical sample sequencer
// Assumes: 50 MHz system clock
// Notes: Register offsets are I2C register addresses
package oss_pkg;
  // ********************
  // Clock and timing
  // ********************
  localparam int SYS_CLK_HZ = 50000000;
  localparam int TICK_HZ = 32000;
  localparam int TICK_DIV = SYS_CLK_HZ / TICK_HZ;
  localparam int TICK_NS = 31250;
  localparam int COMPUTE_GEST_US = 68;
  localparam int COMPUTE_PROX_US = 20;
  localparam int SLEEP_US = 200;
  localparam int MAX_FS_HZ = 1400;
  // Microseconds rounded up to sample-clock ticks
  localparam int COMPUTE_GEST_TICKS = (COMPUTE_GEST_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int COMPUTE_PROX_TICKS = (COMPUTE_PROX_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int SLEEP_TICKS = (SLEEP_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int MIN_PERIOD_TICKS = TICK_HZ / MAX_FS_HZ;
  // ********************
  // I2C
  // ********************
  localparam logic [6:0] SLAVE_ADDR = 7'h64;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] REG_TRIM = 8'h18;
  localparam logic [7:0] REG_GEST_DLY = 8'h20;
  localparam logic [7:0] REG_GEST_SPC = 8'h21;
  localparam logic [7:0] REG_PROX_DLY = 8'h22;
  localparam logic [7:0] REG_PROX_SPC = 8'h23;
  localparam logic [7:0] REG_FS_SEL = 8'h40;
  localparam logic [7:0] REG_MODE = 8'h45;
  localparam logic [7:0] REG_DECIM = 8'h46;
  localparam logic [7:0] REG_PULSES = 8'h47;
  localparam logic [7:0] REG_ADC_IN = 8'h48;
  localparam logic [7:0] REG_PROX_HI = 8'h50;
  localparam logic [7:0] REG_PROX_LO = 8'h51;
  localparam logic [7:0] REG_GEST_HI = 8'h52;
  localparam logic [7:0] REG_GEST_LO = 8'h53;
  localparam logic [7:0] REG_FIFO = 8'h60;
  localparam logic [3:0] MODE_PROX = 4'h1;
  localparam logic [3:0] MODE_GEST = 4'h8;
  localparam int FIFO_DEPTH = 32;
endpackage

// *** hdl/optical_sample_sequencer.sv ***
// Purpose: Sample timing, accumulation, decimation and I2C register slave
// Assumes: SCL and SDA arrive asynchronously and are synchronised here
// Notes: ADC result is supplied by the analog side on adc_data_in
//
// Contract
// (R01) Sequencer steps on a 32 kHz sample-rate tick.
// (R02) Trim register bits 5:0 fine-tune the tick divider.
// (R03) Per-mode sampling period, frequency capped at 1.4 kHz; code floors the period at 22 ticks, about 1.45 kHz.
// (R04) Full pulse train always completes, even past the period.
// (R05) Per-mode LED start delay, six-bit field in microseconds.
// (R06) Pulse spacing from per-mode eight-bit field; host keeps it 19 us or more.
// (R07) Host keeps spacing at least twice window width plus 11 us.
// (R08) Gesture compute time 68 us after pulse train.
// (R09) Proximity compute time 20 us after pulse train.
// (R10) At least 200 us sleep between samples.
// (R11) Sample is sum of 1 to 63 pulse results.
// (R12) Sense window aligned to each LED pulse.
// (R13) Each 14-bit ADC result added to the running sum.
// (R14) Per-period sum saturates at 16 bits.
// (R15) Output registers hold 20 bits; FIFO words are 16 bits.
// (R16) Decimation updates outputs every Nth sample with sum of N.
// (R17) FIFO word is decimated sum shifted right by log2 N.
// (R18) Separate factors; equal lets both slots fill FIFO, else one.
// (R19) Registers reached only through the I2C slave.
// (R20) Standard and fast mode I2C slave up to 400 kbps.
// (R21) Fixed slave address 0x64.
// (R22) Mode value 0x1 starts proximity operation.
// (R23) Mode value 0x8 starts gesture operation.
// (R24) Writes are one 16-bit word; FIFO read pops the word.
// (R25) Timings counted in sample-clock ticks, rounded up.
// (R26) Outputs and FIFO updated in the same cycle.
`timescale 1ns/100ps
module optical_sample_sequencer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Analog front end
  input wire logic [13:0] adc_data_in,
  output logic led_pulse_out,
  output logic sense_window_out
);
  // ********************
  // Types and helpers
  // ********************
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_DELAY = 3'b001, SQ_PULSE = 3'b010,
    SQ_COMPUTE = 3'b011, SQ_SLEEP = 3'b100, SQ_WAIT = 3'b101
  } seq_state_t;
  typedef enum logic [2:0] {
    I2_IDLE = 3'b000, I2_ADDR = 3'b001, I2_ACK = 3'b010,
    I2_RX = 3'b011, I2_TX = 3'b100, I2_TXACK = 3'b101
  } i2c_state_t;

  // Microseconds to ticks, rounded up
  function automatic logic [7:0] us_ticks(input logic [7:0] us);
    logic [17:0] ns;
    ns = 18'(us) * 18'd1000;
    return 8'((ns + 18'(oss_pkg::TICK_NS - 1)) / 18'(oss_pkg::TICK_NS));
  endfunction

  // Decimation factor 2**code, code above 5 clamps to 32
  function automatic logic [2:0] dec_shift(input logic [2:0] code);
    return (code > 3'd5) ? 3'd5 : code;
  endfunction

  // ********************
  // Registers
  // ********************
  logic [5:0] trim_ff;
  logic [5:0] gest_dly_ff, prox_dly_ff;
  logic [7:0] gest_spc_ff, prox_spc_ff;
  logic [15:0] fs_sel_ff;
  logic [3:0] mode_ff;
  logic [7:0] decim_ff;
  logic [11:0] pulses_ff;
  logic [19:0] prox_out_ff, gest_out_ff;
  logic [15:0] fifo_mem [oss_pkg::FIFO_DEPTH];
  logic [4:0] fifo_wp_ff, fifo_rp_ff;
  logic [5:0] fifo_cnt_ff;

  // ********************
  // Sample-rate tick
  // ********************
  logic [10:0] div_ff;
  logic tick;
  logic [10:0] div_top;
  // (R01) (R02) 32 kHz tick, trim shifts divider around nominal
  assign div_top = 11'(oss_pkg::TICK_DIV - 1) + 11'(trim_ff) - 11'd32;
  assign tick = (div_ff >= div_top);
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      div_ff <= '0;
    end else begin
      div_ff <= tick ? 11'd0 : div_ff + 11'd1;
    end
  end

  // ********************
  // Sequencer
  // ********************
  seq_state_t st_ff;
  logic [7:0] tcnt_ff;
  logic [5:0] pcnt_ff;
  logic [15:0] per_ff;
  logic [15:0] acc_ff;
  logic [24:0] dsum_ff [2];
  logic [5:0] dcnt_ff [2];
  logic slot_gest;
  logic [5:0] npulse;
  logic [7:0] spc_ticks;
  logic [15:0] per_lim;
  logic adc_strobe;
  logic [16:0] acc_sum;
  assign slot_gest = (mode_ff == oss_pkg::MODE_GEST);
  assign npulse = slot_gest ? pulses_ff[11:6] : pulses_ff[5:0];
  // (R06) Spacing field per mode, in ticks
  assign spc_ticks = us_ticks(slot_gest ? gest_spc_ff : prox_spc_ff);
  // (R03) Period in ticks, never shorter than 22 ticks, 32000/1400 rounded down
  assign per_lim = (slot_gest ? fs_sel_ff[15:8] : fs_sel_ff[7:0]) <
    8'(oss_pkg::MIN_PERIOD_TICKS) ? 16'(oss_pkg::MIN_PERIOD_TICKS) :
    16'(slot_gest ? fs_sel_ff[15:8] : fs_sel_ff[7:0]);
  // (R12) Window and LED share the tick in which a pulse fires
  assign adc_strobe = (st_ff == SQ_PULSE) && tick && (tcnt_ff == 8'd0);
  assign acc_sum = 17'(acc_ff) + 17'(adc_data_in);

  // Main sequence, all timing counted in ticks (R25)
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_ff <= SQ_IDLE;
      tcnt_ff <= '0;
      pcnt_ff <= '0;
      per_ff <= '0;
    end else if (mode_ff != oss_pkg::MODE_PROX && !slot_gest) begin
      st_ff <= SQ_IDLE;
    end else if (tick) begin
      per_ff <= per_ff + 16'd1;
      case (st_ff)
        // (R22) (R23) Mode selects timing set
        SQ_IDLE: begin
          st_ff <= SQ_DELAY;
          per_ff <= '0;
          // (R05) Start delay
          tcnt_ff <= us_ticks(8'(slot_gest ? gest_dly_ff : prox_dly_ff));
        end
        SQ_DELAY: begin
          if (tcnt_ff <= 8'd1) begin
            st_ff <= SQ_PULSE;
            tcnt_ff <= '0;
            // (R11) Count of 0 is treated as 1
            pcnt_ff <= (npulse == 6'd0) ? 6'd1 : npulse;
          end else begin
            tcnt_ff <= tcnt_ff - 8'd1;
          end
        end
        SQ_PULSE: begin
          // (R04) Train ends only on pulse count, period ignored
          if (tcnt_ff == 8'd0) begin
            if (pcnt_ff == 6'd1) begin
              st_ff <= SQ_COMPUTE;
              // (R08) (R09) Compute time per mode
              tcnt_ff <= slot_gest ? 8'(oss_pkg::COMPUTE_GEST_TICKS) :
                8'(oss_pkg::COMPUTE_PROX_TICKS);
            end else begin
              tcnt_ff <= (spc_ticks == 8'd0) ? 8'd0 : spc_ticks - 8'd1;
            end
            pcnt_ff <= pcnt_ff - 6'd1;
          end else begin
            tcnt_ff <= tcnt_ff - 8'd1;
          end
        end
        SQ_COMPUTE: begin
          if (tcnt_ff <= 8'd1) begin
            st_ff <= SQ_SLEEP;
            // (R10) Minimum sleep
            tcnt_ff <= 8'(oss_pkg::SLEEP_TICKS);
          end else begin
            tcnt_ff <= tcnt_ff - 8'd1;
          end
        end
        SQ_SLEEP: begin
          if (tcnt_ff <= 8'd1) begin
            st_ff <= SQ_WAIT;
          end else begin
            tcnt_ff <= tcnt_ff - 8'd1;
          end
        end
        default: begin
          if (per_ff + 16'd1 >= per_lim) begin
            st_ff <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // LED and sense window outputs
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      led_pulse_out <= 1'b0;
      sense_window_out <= 1'b0;
    end else begin
      // (R12) Window coincides with LED pulse
      led_pulse_out <= (st_ff == SQ_PULSE) && (tcnt_ff == 8'd0);
      sense_window_out <= (st_ff == SQ_PULSE) && (tcnt_ff == 8'd0);
    end
  end

  // Pulse accumulation
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || st_ff == SQ_IDLE) begin
      acc_ff <= '0;
    end else if (adc_strobe) begin
      // (R13) (R14) Add 14-bit result, saturate at 16 bits
      acc_ff <= acc_sum[16] ? 16'hffff : acc_sum[15:0];
    end
  end

  // Decimation and output update
  logic sample_done;
  logic [2:0] sh;
  logic [24:0] tot;
  logic [15:0] fifo_word;
  logic fifo_push;
  logic fifo_pop;
  logic slot_to_fifo;
  assign sample_done = tick && (st_ff == SQ_COMPUTE) && (tcnt_ff <= 8'd1);
  assign sh = dec_shift(slot_gest ? decim_ff[6:4] : decim_ff[2:0]);
  assign tot = dsum_ff[slot_gest] + 25'(acc_ff);
  // (R17) Divide by N before the FIFO
  assign fifo_word = 16'(tot >> sh);
  // (R18) Equal factors: both slots; else only the chosen slot
  assign slot_to_fifo = (decim_ff[2:0] == decim_ff[6:4]) ? 1'b1 : (slot_gest == decim_ff[7]);
  // (R16) Nth sample completes the group
  assign fifo_push = sample_done && (dcnt_ff[slot_gest] + 6'd1 >= (6'd1 << sh)) &&
    slot_to_fifo && (fifo_cnt_ff != 6'(oss_pkg::FIFO_DEPTH));
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      dsum_ff[0] <= '0;
      dsum_ff[1] <= '0;
      dcnt_ff[0] <= '0;
      dcnt_ff[1] <= '0;
      prox_out_ff <= '0;
      gest_out_ff <= '0;
    end else if (sample_done) begin
      if (dcnt_ff[slot_gest] + 6'd1 >= (6'd1 << sh)) begin
        dsum_ff[slot_gest] <= '0;
        dcnt_ff[slot_gest] <= '0;
        // (R15) (R26) 20-bit output written with the FIFO push
        if (slot_gest) begin
          gest_out_ff <= (|tot[24:20]) ? 20'hfffff : tot[19:0];
        end else begin
          prox_out_ff <= (|tot[24:20]) ? 20'hfffff : tot[19:0];
        end
      end else begin
        dsum_ff[slot_gest] <= tot;
        dcnt_ff[slot_gest] <= dcnt_ff[slot_gest] + 6'd1;
      end
    end
  end

  // FIFO storage, push and pop in the same cycle are both honoured
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      fifo_wp_ff <= '0;
      fifo_rp_ff <= '0;
      fifo_cnt_ff <= '0;
    end else begin
      if (fifo_push) begin
        fifo_mem[fifo_wp_ff] <= fifo_word;
        fifo_wp_ff <= fifo_wp_ff + 5'd1;
      end
      // (R24) Read of the FIFO register frees the word
      if (fifo_pop) begin
        fifo_rp_ff <= fifo_rp_ff + 5'd1;
      end
      fifo_cnt_ff <= fifo_cnt_ff + 6'(fifo_push) - 6'(fifo_pop);
    end
  end

  // ********************
  // I2C slave
  // ********************
  logic [2:0] scl_sy_ff, sda_sy_ff;
  logic scl_rise, scl_fall, start_c, stop_c;
  // Two-flop sync, third stage only for edge detection
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      scl_sy_ff <= 3'b111;
      sda_sy_ff <= 3'b111;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
    end
  end
  assign scl_rise = scl_sy_ff[1] && !scl_sy_ff[2];
  assign scl_fall = !scl_sy_ff[1] && scl_sy_ff[2];
  assign start_c = scl_sy_ff[1] && scl_sy_ff[2] && !sda_sy_ff[1] && sda_sy_ff[2];
  assign stop_c = scl_sy_ff[1] && scl_sy_ff[2] && sda_sy_ff[1] && !sda_sy_ff[2];

  i2c_state_t i2_ff;
  logic [7:0] sh_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic rd_ff, ack_ok_ff;
  logic [7:0] ptr_ff, hi_ff;
  logic [15:0] tx_ff;
  logic wr_go;
  logic [15:0] rd_val;
  logic [7:0] rx_byte;
  assign rx_byte = {sh_ff[6:0], sda_sy_ff[1]};

  // Register read mux
  always_comb begin
    rd_val = 16'h0000;
    if (ptr_ff == oss_pkg::REG_TRIM) begin
      rd_val = {10'h000, trim_ff};
    end else if (ptr_ff == oss_pkg::REG_GEST_DLY) begin
      rd_val = {10'h000, gest_dly_ff};
    end else if (ptr_ff == oss_pkg::REG_GEST_SPC) begin
      rd_val = {8'h00, gest_spc_ff};
    end else if (ptr_ff == oss_pkg::REG_PROX_DLY) begin
      rd_val = {10'h000, prox_dly_ff};
    end else if (ptr_ff == oss_pkg::REG_PROX_SPC) begin
      rd_val = {8'h00, prox_spc_ff};
    end else if (ptr_ff == oss_pkg::REG_FS_SEL) begin
      rd_val = fs_sel_ff;
    end else if (ptr_ff == oss_pkg::REG_MODE) begin
      rd_val = {9'h000, st_ff, mode_ff};
    end else if (ptr_ff == oss_pkg::REG_DECIM) begin
      rd_val = {8'h00, decim_ff};
    end else if (ptr_ff == oss_pkg::REG_PULSES) begin
      rd_val = {4'h0, pulses_ff};
    end else if (ptr_ff == oss_pkg::REG_PROX_HI) begin
      rd_val = {12'h000, prox_out_ff[19:16]};
    end else if (ptr_ff == oss_pkg::REG_PROX_LO) begin
      rd_val = prox_out_ff[15:0];
    end else if (ptr_ff == oss_pkg::REG_GEST_HI) begin
      rd_val = {12'h000, gest_out_ff[19:16]};
    end else if (ptr_ff == oss_pkg::REG_GEST_LO) begin
      rd_val = gest_out_ff[15:0];
    end else if (ptr_ff == oss_pkg::REG_FIFO) begin
      rd_val = (fifo_cnt_ff == 6'd0) ? 16'h0000 : fifo_mem[fifo_rp_ff];
    end
  end
  assign fifo_pop = (i2_ff == I2_ACK) && scl_fall && rd_ff && (byte_ff == 2'd0) &&
    ack_ok_ff && (ptr_ff == oss_pkg::REG_FIFO) && (fifo_cnt_ff != 6'd0);
  // (R24) Write commits only after the full 16-bit word
  assign wr_go = (i2_ff == I2_RX) && scl_rise && (bit_ff == 4'd7) && (byte_ff == 2'd2);

  // (R19) (R20) Bit engine, SCL-rate independent up to 400 kbps
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || stop_c) begin
      i2_ff <= I2_IDLE;
      sh_ff <= '0;
      bit_ff <= '0;
      byte_ff <= '0;
      rd_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      tx_ff <= '0;
      sda_oe_out <= 1'b0;
    end else if (start_c) begin
      i2_ff <= I2_ADDR;
      bit_ff <= '0;
      sda_oe_out <= 1'b0;
    end else begin
      case (i2_ff)
        I2_ADDR, I2_RX: begin
          if (scl_rise) begin
            sh_ff <= rx_byte;
            bit_ff <= bit_ff + 4'd1;
          end
          if (scl_fall && bit_ff == 4'd8) begin
            bit_ff <= '0;
            i2_ff <= I2_ACK;
            if (i2_ff == I2_ADDR) begin
              // (R21) Match fixed address only
              ack_ok_ff <= (sh_ff[7:1] == oss_pkg::SLAVE_ADDR);
              rd_ff <= sh_ff[0];
              byte_ff <= '0;
              tx_ff <= rd_val;
            end else begin
              if (byte_ff == 2'd0) begin
                ptr_ff <= sh_ff;
              end else if (byte_ff == 2'd1) begin
                hi_ff <= sh_ff;
              end
              byte_ff <= (byte_ff == 2'd2) ? 2'd1 : byte_ff + 2'd1;
            end
            sda_oe_out <= (i2_ff == I2_RX) || (sh_ff[7:1] == oss_pkg::SLAVE_ADDR);
          end
        end
        I2_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            if (!ack_ok_ff) begin
              i2_ff <= I2_IDLE;
            end else if (rd_ff) begin
              i2_ff <= I2_TX;
              sda_oe_out <= !tx_ff[15];
              tx_ff <= {tx_ff[14:0], 1'b1};
            end else begin
              i2_ff <= I2_RX;
            end
          end
        end
        I2_TX: begin
          if (scl_fall) begin
            bit_ff <= bit_ff + 4'd1;
            if (bit_ff == 4'd7) begin
              bit_ff <= '0;
              sda_oe_out <= 1'b0;
              i2_ff <= I2_TXACK;
            end else begin
              sda_oe_out <= !tx_ff[15];
              tx_ff <= {tx_ff[14:0], 1'b1};
            end
          end
        end
        I2_TXACK: begin
          if (scl_rise) begin
            i2_ff <= sda_sy_ff[1] ? I2_IDLE : I2_TXACK;
          end
          if (scl_fall) begin
            i2_ff <= I2_TX;
            sda_oe_out <= !tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b1};
          end
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end
  assign sda_out = 1'b0;

  // Register writes
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      trim_ff <= '0;
      gest_dly_ff <= 6'd23;
      prox_dly_ff <= 6'd23;
      gest_spc_ff <= 8'd19;
      prox_spc_ff <= 8'd19;
      fs_sel_ff <= '0;
      mode_ff <= '0;
      decim_ff <= '0;
      pulses_ff <= {6'd1, 6'd1};
    end else if (wr_go) begin
      if (ptr_ff == oss_pkg::REG_TRIM) begin
        trim_ff <= rx_byte[5:0];
      end else if (ptr_ff == oss_pkg::REG_GEST_DLY) begin
        gest_dly_ff <= rx_byte[5:0];
      end else if (ptr_ff == oss_pkg::REG_GEST_SPC) begin
        gest_spc_ff <= rx_byte;
      end else if (ptr_ff == oss_pkg::REG_PROX_DLY) begin
        prox_dly_ff <= rx_byte[5:0];
      end else if (ptr_ff == oss_pkg::REG_PROX_SPC) begin
        prox_spc_ff <= rx_byte;
      end else if (ptr_ff == oss_pkg::REG_FS_SEL) begin
        fs_sel_ff <= {hi_ff, rx_byte};
      end else if (ptr_ff == oss_pkg::REG_MODE) begin
        mode_ff <= rx_byte[3:0];
      end else if (ptr_ff == oss_pkg::REG_DECIM) begin
        decim_ff <= rx_byte;
      end else if (ptr_ff == oss_pkg::REG_PULSES) begin
        pulses_ff <= {hi_ff[3:0], rx_byte};
      end
    end
  end
endmodule

// *** verif/optical_sample_sequencer_checker.sv ***
// Purpose: Port-level assertions for the optical sample sequencer
// Assumes: One sys_clk_in domain with synchronous active-low reset
// Notes: Attached to the design top by the bind at the foot
`timescale 1ns/100ps
module optical_sample_sequencer_checker (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Analog front end
  input wire logic [13:0] adc_data_in,
  input wire logic led_pulse_out,
  input wire logic sense_window_out
);
  // Trim may move the tick by up to 32 cycles either way
  localparam int PULSE_MIN = oss_pkg::TICK_DIV - 40;
  localparam int PULSE_MAX = oss_pkg::TICK_DIV + 40;
  logic [15:0] hi_len_ff;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Length of the current LED pulse, saturating
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !led_pulse_out) begin
      hi_len_ff <= '0;
    end else if (hi_len_ff != 16'hffff) begin
      hi_len_ff <= hi_len_ff + 16'h0001;
    end
  end
  sequence start_seen;
    scl_in && $fell(sda_in);
  endsequence
  sequence oe_raised;
    $rose(sda_oe_out);
  endsequence
  // ********************
  // Assertions
  // ********************
  a_window_tracks_led: assert property (sense_window_out == led_pulse_out)
    else $error("sense window differs from LED pulse");
  a_sda_value_low: assert property (sda_out == 1'b0)
    else $error("SDA drive value not low");
  a_reset_quiet: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    !resetn_in |=> !sda_oe_out && !led_pulse_out)
    else $error("outputs active after reset");
  a_idle_after_reset: assert property ($rose(resetn_in) |-> !led_pulse_out [*8])
    else $error("LED pulse without a mode command");
  a_oe_moves_scl_low: assert property ($changed(sda_oe_out) |-> $past(scl_in) == 1'b0)
    else $error("SDA drive changed while SCL high");
  a_address_silent: assert property (start_seen |-> !sda_oe_out [*8])
    else $error("SDA driven during address phase");
  a_drive_holds_bit: assert property (oe_raised |-> sda_oe_out [*5])
    else $error("SDA drive shorter than one bit");
  a_pulse_one_tick: assert property ($fell(led_pulse_out) |->
    hi_len_ff >= PULSE_MIN && hi_len_ff <= PULSE_MAX)
    else $error("LED pulse not one sample tick long");
endmodule
bind optical_sample_sequencer optical_sample_sequencer_checker i_optical_sample_sequencer_checker (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .adc_data_in(adc_data_in),
  .led_pulse_out(led_pulse_out), .sense_window_out(sense_window_out));

// *** verif/host_i2c_master.sv ***
// Purpose: Host processor model acting as I2C master
// Assumes: SDA level resolved outside with a pull-up
// Notes: SCL stands high between frames; QUARTER sets the bit rate
`timescale 1ns/100ps
module host_i2c_master #(
  parameter int QUARTER = 2
) (
  // Clock
  input wire logic sys_clk_in,
  // Resolved SDA level
  input wire logic sda_in,
  // Host pin drive
  output logic scl_out,
  output logic sda_low_out
);
  // Bus idle at time zero
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic qtr();
    repeat (QUARTER) @(posedge sys_clk_in);
  endtask
  // Start, also used as repeated start
  task automatic start_cond();
    sda_low_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b0;
    qtr();
  endtask
  // Data set while SCL low, sampled mid high phase
  task automatic bit_xfer(input logic b, output logic seen);
    sda_low_out <= !b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    seen = sda_in;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                           output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(ack_in, s);
    acked = !s;
  endtask
  task automatic write_word(input logic [6:0] addr, input logic [7:0] rg,
                            input logic [15:0] data, output logic acked);
    logic [7:0] rx;
    logic a;
    start_cond();
    byte_xfer({addr, 1'b0}, 1'b1, rx, acked);
    byte_xfer(rg, 1'b1, rx, a);
    byte_xfer(data[15:8], 1'b1, rx, a);
    byte_xfer(data[7:0], 1'b1, rx, a);
    stop_cond();
  endtask
  // fixed address, NACK after low byte
  task automatic read_word(input logic [7:0] rg, output logic [15:0] data);
    logic [7:0] rx;
    logic a;
    start_cond();
    byte_xfer({oss_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
    byte_xfer(rg, 1'b1, rx, a);
    start_cond();
    byte_xfer({oss_pkg::SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
    byte_xfer(8'hff, 1'b0, data[15:8], a);
    byte_xfer(8'hff, 1'b1, data[7:0], a);
    stop_cond();
  endtask
endmodule

// *** verif/optical_sample_sequencer_tb.sv ***
// Purpose: Self-checking bench for the optical sample sequencer
// Assumes: SCL period 160 ns from the host model, pull-up on SDA
// Notes: Output high register assumed to carry bits 19:16
`timescale 1ns/100ps
module optical_sample_sequencer_tb;
  localparam int TIMEOUT = 90000;
  logic sys_clk_in;
  logic resetn_in;
  logic [13:0] adc_data_in;
  logic scl_pin, host_sda_low, sda_oe, sda_drv, sda_pin, led_pulse, sense_window, led_prev, acked;
  logic [15:0] rd;
  int err_total, samples_checked, cycle_count, led_rises;
  // Open-drain SDA: low if any party pulls
  assign sda_pin = ((sda_oe && !sda_drv) || host_sda_low) ? 1'b0 : 1'b1;
  optical_sample_sequencer i_optical_sample_sequencer (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl_pin), .sda_in(sda_pin),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .adc_data_in(adc_data_in),
    .led_pulse_out(led_pulse), .sense_window_out(sense_window));
  host_i2c_master i_host_i2c_master (
    .sys_clk_in(sys_clk_in), .sda_in(sda_pin), .scl_out(scl_pin),
    .sda_low_out(host_sda_low));
  // 50 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // LED edge count and hang guard
  always @(posedge sys_clk_in) begin
    led_prev <= led_pulse;
    if (led_pulse === 1'b1 && led_prev === 1'b0) begin
      led_rises <= led_rises + 1;
    end
    cycle_count <= cycle_count + 1;
    if (cycle_count == TIMEOUT) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] rg, input logic [15:0] exp);
    i_host_i2c_master.read_word(rg, rd);
    check(name, rd, exp);
  endtask
  task automatic wr(input logic [7:0] rg, input logic [15:0] data);
    i_host_i2c_master.write_word(oss_pkg::SLAVE_ADDR, rg, data, acked);
    check("write ack", {15'h0000, acked}, 16'h0001);
  endtask
  task automatic wait_ticks(input int n);
    repeat (n * oss_pkg::TICK_DIV) @(posedge sys_clk_in);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset_values();
    for (int i = 0; i < 4; i++) begin
      rd_chk("rst value", 8'(oss_pkg::REG_GEST_DLY + i), i[0] ? 16'h0013 : 16'h0017);
    end
  endtask
  // spacing kept at 63 us, inside the host's legal range
  task automatic t_reg_access();
    logic [7:0] regs [7] = '{oss_pkg::REG_TRIM, oss_pkg::REG_GEST_DLY, oss_pkg::REG_GEST_SPC,
                             oss_pkg::REG_PROX_DLY, oss_pkg::REG_PROX_SPC,
                             oss_pkg::REG_FS_SEL, oss_pkg::REG_DECIM};
    logic [15:0] vals [7] = '{16'h0020, 16'h0018, 16'h003f, 16'h0017, 16'h003f,
                              16'h1616, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      wr(regs[i], vals[i]);
      rd_chk("register readback", regs[i], vals[i]);
    end
    rd_chk("unmapped read", 8'h48, 16'h0000);
  endtask
  task automatic t_bad_addr();
    i_host_i2c_master.write_word(7'h65, oss_pkg::REG_GEST_DLY, 16'h003f, acked);
    check("foreign address ack", {15'h0000, acked}, 16'h0000);
    rd_chk("foreign write ignored", oss_pkg::REG_GEST_DLY, 16'h0018);
  endtask
  // Two proximity pulses of 0x1234 sum to 0x2468
  task automatic proximity_sample_duration();
    int n0;
    wr(oss_pkg::REG_PULSES, 16'h0142);
    adc_data_in <= 14'h1234;
    n0 = led_rises;
    wr(oss_pkg::REG_MODE, 16'h0001);
    wait_ticks(16);
    check("prox pulse count", 16'(led_rises - n0), 16'h0002);
    rd_chk("prox sum low", oss_pkg::REG_PROX_LO, 16'h2468);
    rd_chk("prox sum high", oss_pkg::REG_PROX_HI, 16'h0000);
    rd_chk("prox fifo word", oss_pkg::REG_FIFO, 16'h2468);
  endtask
  // Five full-scale pulses overflow 16 bits and must clamp
  task automatic gesture_sample_duration_sat();
    int n0;
    adc_data_in <= 14'h3fff;
    n0 = led_rises;
    wr(oss_pkg::REG_MODE, 16'h0008);
    wait_ticks(26);
    check("gest pulse count", 16'(led_rises - n0), 16'h0005);
    rd_chk("gest sum low", oss_pkg::REG_GEST_LO, 16'hffff);
    rd_chk("gest sum high", oss_pkg::REG_GEST_HI, 16'h0000);
    rd_chk("gest fifo word", oss_pkg::REG_FIFO, 16'hffff);
  endtask
  // Main sequence
  initial begin
    resetn_in = 1'b0;
    adc_data_in = 14'h0000;
    led_prev = 1'b0;
    err_total = 0;
    samples_checked = 0;
    cycle_count = 0;
    led_rises = 0;
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_reset_values();
    t_reg_access();
    t_bad_addr();
    proximity_sample_duration();
    gesture_sample_duration_sat();
    tally_and_finish();
  end
endmodule
